// [poll_rate_divider.sv]
// module: per-channel poll strobes at the base rate or at a quarter of it
`timescale 1ns/1ps
module poll_rate_divider #(
  parameter int CHANNELS = 8
) (
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic                base_poll_tick,
  input  wire logic [CHANNELS-1:0] slow_poll,
  output logic      [CHANNELS-1:0] poll_strobe
);

  // ----------------------------------------------------------------
  // shared quarter-rate phase counter
  // ----------------------------------------------------------------
  logic [1:0] phase;

  // one counter for all channels keeps slow channels aligned to each other
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase <= 2'h0;
    end else if (base_poll_tick) begin
      phase <= phase + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // per-channel strobe select
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_strobe
    // slow channels poll on one base tick in four
    always_comb begin
      if (slow_poll[ch]) begin
        poll_strobe[ch] = base_poll_tick && (phase == sleep_poll_pkg::SLOW_POLL_LAST);
      end else begin
        poll_strobe[ch] = base_poll_tick;
      end
    end
  end

endmodule

// [sleep_poll_pkg.sv]
// package: constants, register map and frame layouts for the sleep polling configuration bank
package sleep_poll_pkg;

  // ----------------------------------------------------------------
  // channel counts and widths
  // ----------------------------------------------------------------
  localparam int PROG_CHANNELS   = 8;
  localparam int GROUND_CHANNELS = 14;
  localparam int CURRENT_W       = 8;   // polling current in tenths of a milliamp
  localparam int FRAME_BITS      = 32;
  localparam int ADDR_W          = 7;
  localparam int DATA_W          = 24;
  localparam int REPLY_DATA_W    = 22;

  // ----------------------------------------------------------------
  // register addresses (7-bit frame address field)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_PROG_CHANNEL_POLL_CURRENT_SELECT   = 7'h16;
  localparam logic [6:0] ADDR_GROUND_CHANNEL_POLL_CURRENT_SELECT = 7'h17;
  localparam logic [6:0] ADDR_PROG_CHANNEL_SLOW_POLL_ENABLE      = 7'h18;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0]  RESET_PROG_CURRENT_SELECT   = 8'h00;
  localparam logic [13:0] RESET_GROUND_CURRENT_SELECT = 14'h0000;
  localparam logic [7:0]  RESET_PROG_SLOW_POLL        = 8'h00;
  localparam logic [31:0] RESET_REPLY                 = 32'h0000_0000;

  // ----------------------------------------------------------------
  // default sleep polling currents, tenths of a milliamp
  // ----------------------------------------------------------------
  localparam logic [7:0] DEFAULT_BATTERY_CURRENT = 8'h16;  // 2.2 mA
  localparam logic [7:0] DEFAULT_GROUND_CURRENT  = 8'h0a;  // 1.0 mA

  // ----------------------------------------------------------------
  // slow polling: interval multiplier and its counter
  // ----------------------------------------------------------------
  localparam int         SLOW_POLL_FACTOR = 4;
  localparam logic [1:0] SLOW_POLL_LAST   = 2'h3;  // SLOW_POLL_FACTOR - 1

  // frame bit counter
  localparam logic [5:0] FRAME_BITS_COUNT = 6'h20;

  // command frame as the host shifts it in, msb first
  typedef struct packed {
    logic [6:0]  addr;
    logic        write;
    logic [23:0] data;
  } command_frame_s;

  // reply frame as the device shifts it out, msb first
  typedef struct packed {
    logic [7:0]  pad;
    logic        fault_status;
    logic        int_flag;
    logic [21:0] data;
  } reply_frame_s;

endpackage

// [sleep_polling_config_regs.sv]
// module: serial-accessed sleep polling configuration registers and their per-channel effects
`timescale 1ns/1ps
module sleep_polling_config_regs #(
  parameter int PROG_CHANNELS   = sleep_poll_pkg::PROG_CHANNELS,
  parameter int GROUND_CHANNELS = sleep_poll_pkg::GROUND_CHANNELS
) (
  input  wire logic                                                  ref_clk,
  input  wire logic                                                  reset,
  // serial link pins
  input  wire logic                                                  spi_sclk,
  input  wire logic                                                  spi_cs_n,
  input  wire logic                                                  spi_mosi,
  output logic                                                       spi_miso,
  output logic                                                       spi_miso_oe,
  // status carried in every reply
  input  wire logic                                                  fault_status,
  input  wire logic                                                  int_flag,
  // channel context from the rest of the device
  input  wire logic                                                  sleep_polling_mode,
  input  wire logic                                                  base_poll_tick,
  input  wire logic [PROG_CHANNELS-1:0]                              prog_is_battery_switch,
  input  wire logic [PROG_CHANNELS-1:0][sleep_poll_pkg::CURRENT_W-1:0]   prog_contact_cleaning_current,
  input  wire logic [GROUND_CHANNELS-1:0][sleep_poll_pkg::CURRENT_W-1:0] ground_contact_cleaning_current,
  // per-channel sleep polling controls
  output logic      [PROG_CHANNELS-1:0][sleep_poll_pkg::CURRENT_W-1:0]   prog_poll_current,
  output logic      [GROUND_CHANNELS-1:0][sleep_poll_pkg::CURRENT_W-1:0] ground_poll_current,
  output logic      [PROG_CHANNELS-1:0]                              prog_poll_strobe,
  output logic      [GROUND_CHANNELS-1:0]                            ground_poll_strobe,
  // raw register contents
  output logic      [PROG_CHANNELS-1:0]                              prog_channel_poll_current_select,
  output logic      [GROUND_CHANNELS-1:0]                            ground_channel_poll_current_select,
  output logic      [PROG_CHANNELS-1:0]                              prog_channel_slow_poll_enable
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sclk_sync;
  logic [2:0] cs_n_sync;
  logic [1:0] mosi_sync;

  // stage 0 feeds stage 1 only; stage 2 is the edge-detect history
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sclk_sync <= 3'h0;
      cs_n_sync <= 3'h7;
      mosi_sync <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], spi_sclk};
      cs_n_sync <= {cs_n_sync[1:0], spi_cs_n};
      mosi_sync <= {mosi_sync[0], spi_mosi};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  logic in_frame;

  // edges seen on the synchronised copies only
  assign sclk_rise   = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall   = ~sclk_sync[1] & sclk_sync[2];
  assign frame_start = ~cs_n_sync[1] & cs_n_sync[2];
  assign frame_end   = cs_n_sync[1] & ~cs_n_sync[2];
  assign in_frame    = ~cs_n_sync[1];

  // ----------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------
  logic [31:0] shift_in;
  logic [5:0]  bit_count;

  // mode 0: host data sampled on rising sclk, msb first
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shift_in  <= 32'h0000_0000;
      bit_count <= 6'h00;
    end else if (frame_start) begin
      bit_count <= 6'h00;
    end else if (in_frame && sclk_rise) begin
      shift_in <= {shift_in[30:0], mosi_sync[1]};
      if (bit_count != 6'h3f) begin
        bit_count <= bit_count + 6'h01;  // saturates so long frames stay invalid
      end
    end
  end

  sleep_poll_pkg::command_frame_s command;
  logic                           frame_valid;
  logic                           do_write;

  // only an exact 32-bit frame is acted on; short or long frames are dropped
  assign command     = sleep_poll_pkg::command_frame_s'(shift_in);
  assign frame_valid = frame_end && (bit_count == sleep_poll_pkg::FRAME_BITS_COUNT);
  assign do_write    = frame_valid && command.write;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // unused upper bits are not stored and read back as zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prog_channel_poll_current_select <= sleep_poll_pkg::RESET_PROG_CURRENT_SELECT;
    end else if (do_write && command.addr == sleep_poll_pkg::ADDR_PROG_CHANNEL_POLL_CURRENT_SELECT) begin
      prog_channel_poll_current_select <= command.data[PROG_CHANNELS-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ground_channel_poll_current_select <= sleep_poll_pkg::RESET_GROUND_CURRENT_SELECT;
    end else if (do_write && command.addr == sleep_poll_pkg::ADDR_GROUND_CHANNEL_POLL_CURRENT_SELECT) begin
      ground_channel_poll_current_select <= command.data[GROUND_CHANNELS-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prog_channel_slow_poll_enable <= sleep_poll_pkg::RESET_PROG_SLOW_POLL;
    end else if (do_write && command.addr == sleep_poll_pkg::ADDR_PROG_CHANNEL_SLOW_POLL_ENABLE) begin
      prog_channel_slow_poll_enable <= command.data[PROG_CHANNELS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // read-back and reply word
  // ----------------------------------------------------------------
  logic [21:0] read_data;

  // contents after this frame's write; unmapped addresses read zero
  always_comb begin
    read_data = 22'h00_0000;
    case (command.addr)
      sleep_poll_pkg::ADDR_PROG_CHANNEL_POLL_CURRENT_SELECT: begin
        read_data = {14'h0000, do_write ? command.data[PROG_CHANNELS-1:0] : prog_channel_poll_current_select};
      end
      sleep_poll_pkg::ADDR_GROUND_CHANNEL_POLL_CURRENT_SELECT: begin
        read_data = {8'h00, do_write ? command.data[GROUND_CHANNELS-1:0] : ground_channel_poll_current_select};
      end
      sleep_poll_pkg::ADDR_PROG_CHANNEL_SLOW_POLL_ENABLE: begin
        read_data = {14'h0000, do_write ? command.data[PROG_CHANNELS-1:0] : prog_channel_slow_poll_enable};
      end
      default: begin
        read_data = 22'h00_0000;
      end
    endcase
  end

  sleep_poll_pkg::reply_frame_s reply;

  // reply is captured at frame end and shifted out in the next frame,
  // since the address is only known once the whole command is in
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reply <= sleep_poll_pkg::RESET_REPLY;
    end else if (frame_valid) begin
      reply.pad          <= 8'h00;
      reply.fault_status <= fault_status;
      reply.int_flag     <= int_flag;
      reply.data         <= read_data;
    end
  end

  // ----------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------
  logic [31:0] shift_out;

  // first bit presented at chip select fall, next bits on falling sclk
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shift_out <= 32'h0000_0000;
    end else if (frame_start) begin
      shift_out <= reply;
    end else if (in_frame && sclk_fall) begin
      shift_out <= {shift_out[30:0], 1'b0};
    end
  end

  // miso driven only inside a frame so several devices may share it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso    <= shift_out[31];
      spi_miso_oe <= in_frame;
    end
  end

  // ----------------------------------------------------------------
  // per-channel polling currents
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < PROG_CHANNELS; ch++) begin : g_prog_current
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        prog_poll_current[ch] <= sleep_poll_pkg::DEFAULT_GROUND_CURRENT;
      end else if (prog_channel_poll_current_select[ch]) begin
        prog_poll_current[ch] <= prog_contact_cleaning_current[ch];
      end else if (prog_is_battery_switch[ch]) begin
        prog_poll_current[ch] <= sleep_poll_pkg::DEFAULT_BATTERY_CURRENT;
      end else begin
        prog_poll_current[ch] <= sleep_poll_pkg::DEFAULT_GROUND_CURRENT;
      end
    end
  end

  for (genvar ch = 0; ch < GROUND_CHANNELS; ch++) begin : g_ground_current
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        ground_poll_current[ch] <= sleep_poll_pkg::DEFAULT_GROUND_CURRENT;
      end else if (ground_channel_poll_current_select[ch]) begin
        ground_poll_current[ch] <= ground_contact_cleaning_current[ch];
      end else begin
        ground_poll_current[ch] <= sleep_poll_pkg::DEFAULT_GROUND_CURRENT;
      end
    end
  end

  // ----------------------------------------------------------------
  // polling rate
  // ----------------------------------------------------------------
  logic awake_tick;

  // base tick only counts while sleeping; the rate itself is set elsewhere
  assign awake_tick = base_poll_tick & sleep_polling_mode;

  poll_rate_divider #(
    .CHANNELS (PROG_CHANNELS)
  ) u_prog_rate (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .base_poll_tick (awake_tick),
    .slow_poll      (prog_channel_slow_poll_enable),
    .poll_strobe    (prog_poll_strobe)
  );

  // ground channels have no slow option in this bank
  assign ground_poll_strobe = {GROUND_CHANNELS{awake_tick}};

endmodule

// [sleep_polling_config_regs_chk.sv]
// checker: port properties of the sleep polling configuration bank
`timescale 1ns/1ps
module sleep_polling_config_regs_chk #(
  parameter int PROG_CHANNELS   = 8,
  parameter int GROUND_CHANNELS = 14
) (
  input wire logic                                 ref_clk,
  input wire logic                                 reset,
  input wire logic                                 spi_cs_n,
  input wire logic                                 spi_miso_oe,
  input wire logic                                 sleep_polling_mode,
  input wire logic                                 base_poll_tick,
  input wire logic [PROG_CHANNELS-1:0]             prog_is_battery_switch,
  input wire logic [PROG_CHANNELS-1:0][7:0]        prog_contact_cleaning_current,
  input wire logic [GROUND_CHANNELS-1:0][7:0]      ground_contact_cleaning_current,
  input wire logic [PROG_CHANNELS-1:0][7:0]        prog_poll_current,
  input wire logic [GROUND_CHANNELS-1:0][7:0]      ground_poll_current,
  input wire logic [PROG_CHANNELS-1:0]             prog_poll_strobe,
  input wire logic [GROUND_CHANNELS-1:0]           ground_poll_strobe,
  input wire logic [PROG_CHANNELS-1:0]             prog_channel_poll_current_select,
  input wire logic [GROUND_CHANNELS-1:0]           ground_channel_poll_current_select,
  input wire logic [PROG_CHANNELS-1:0]             prog_channel_slow_poll_enable
);
  logic       gated;
  logic       slow_hit;
  logic       seen;
  logic [1:0] since;
  // gated tick and any slow channel striking
  assign gated    = base_poll_tick & sleep_polling_mode;
  assign slow_hit = |(prog_poll_strobe & prog_channel_slow_poll_enable);
  // phase tracker; the shared phase is unknown until a slow strobe is seen
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seen  <= 1'b0;
      since <= 2'h0;
    end else if (slow_hit) begin
      seen  <= 1'b1;
      since <= 2'h0;
    end else if (gated) begin
      since <= since + 2'h1;
    end
  end
  // per-channel current selection, one cycle behind its cause
  for (genvar i = 0; i < PROG_CHANNELS; i++) begin : g_prog
    chk_prog_current_pick: assert property (@(posedge ref_clk) disable iff (reset)
      !$past(reset) |-> prog_poll_current[i] == ($past(prog_channel_poll_current_select[i]) ?
      $past(prog_contact_cleaning_current[i]) : $past(prog_is_battery_switch[i]) ? 8'h16 : 8'h0a))
      else $error("programmable channel current wrong");
  end
  for (genvar i = 0; i < GROUND_CHANNELS; i++) begin : g_gnd
    chk_ground_current_pick: assert property (@(posedge ref_clk) disable iff (reset)
      !$past(reset) |-> ground_poll_current[i] == ($past(ground_channel_poll_current_select[i]) ?
      $past(ground_contact_cleaning_current[i]) : 8'h0a))
      else $error("ground channel current wrong");
  end
  // strobe timing against the base tick
  chk_fast_every_tick: assert property (@(posedge ref_clk) disable iff (reset)
    gated |-> &(prog_poll_strobe | prog_channel_slow_poll_enable))
    else $error("fast channel missed a tick");
  chk_quiet_no_tick: assert property (@(posedge ref_clk) disable iff (reset)
    !gated |-> prog_poll_strobe == '0 && ground_poll_strobe == '0)
    else $error("strobe without gated tick");
  chk_ground_each_tick: assert property (@(posedge ref_clk) disable iff (reset)
    gated |-> &ground_poll_strobe)
    else $error("ground channel missed a tick");
  chk_slow_fourth_tick: assert property (@(posedge ref_clk) disable iff (reset)
    gated && seen && (|prog_channel_slow_poll_enable) |-> slow_hit == (since == 2'h3))
    else $error("slow strobe off its fourth tick");
  // registers move only once the frame has closed
  chk_regs_frame_end: assert property (@(posedge ref_clk) disable iff (reset)
    !$stable({prog_channel_poll_current_select, ground_channel_poll_current_select,
    prog_channel_slow_poll_enable}) |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("register changed inside a frame");
  chk_oe_after_frame: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(spi_cs_n) |-> ##[1:6] !spi_miso_oe)
    else $error("reply driver not released");
  // reply driver must be on once select has settled low
  chk_oe_in_frame: assert property (@(posedge ref_clk) disable iff (reset)
    !spi_cs_n && !$past(spi_cs_n, 3) |-> spi_miso_oe)
    else $error("reply driver off inside a frame");
endmodule
bind sleep_polling_config_regs sleep_polling_config_regs_chk #(.PROG_CHANNELS(PROG_CHANNELS),
  .GROUND_CHANNELS(GROUND_CHANNELS)) chk_inst (.*);

// [sleep_polling_config_regs_tb.sv]
// testbench: register frames, polling currents and poll strobes against a reference model
`timescale 1ns/1ps
module sleep_polling_config_regs_tb;
  logic              ref_clk, reset, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, miso_wire;
  logic              fault_status, int_flag, sleep_polling_mode, base_poll_tick;
  logic [7:0]        prog_is_battery_switch, prog_poll_strobe, prog_channel_poll_current_select;
  logic [7:0]        prog_channel_slow_poll_enable;
  logic [13:0]       ground_poll_strobe, ground_channel_poll_current_select;
  logic [7:0][7:0]   prog_contact_cleaning_current, prog_poll_current;
  logic [13:0][7:0]  ground_contact_cleaning_current, ground_poll_current;
  logic [31:0]       exp_reply;
  logic [23:0]       d;
  int                errors = 0, checked = 0, cycles = 0, rp, rg, rs;
  sleep_polling_config_regs sleep_polling_config_regs_inst (
    .ref_clk(ref_clk), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .fault_status(fault_status), .int_flag(int_flag),
    .sleep_polling_mode(sleep_polling_mode), .base_poll_tick(base_poll_tick),
    .prog_is_battery_switch(prog_is_battery_switch),
    .prog_contact_cleaning_current(prog_contact_cleaning_current),
    .ground_contact_cleaning_current(ground_contact_cleaning_current),
    .prog_poll_current(prog_poll_current), .ground_poll_current(ground_poll_current),
    .prog_poll_strobe(prog_poll_strobe), .ground_poll_strobe(ground_poll_strobe),
    .prog_channel_poll_current_select(prog_channel_poll_current_select),
    .ground_channel_poll_current_select(ground_channel_poll_current_select),
    .prog_channel_slow_poll_enable(prog_channel_slow_poll_enable));
  spi_host_model spi_host_model_inst (.ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(miso_wire));
  // clock; a released line has no pull, so it shows the inverse of its last bit
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  assign miso_wire = spi_miso_oe ? spi_miso : ~spi_miso;
  // hang guard, well above the ~11k cycles the run needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors = errors + 1;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one frame; the reply carries the previous command's outcome
  task automatic frame(input logic [6:0] a, input logic w, input logic [23:0] dd);
    logic [31:0] rep;
    @(negedge ref_clk);
    fault_status = 1'($urandom);
    int_flag     = 1'($urandom);
    spi_host_model_inst.xfer({a, w, dd}, rep);
    check(rep, exp_reply);
    if (w && a == 7'h16) rp = int'(dd[7:0]);
    if (w && a == 7'h17) rg = int'(dd[13:0]);
    if (w && a == 7'h18) rs = int'(dd[7:0]);
    exp_reply = {8'h00, fault_status, int_flag, 22'((a == 7'h16) ? rp : (a == 7'h17) ? rg : (a == 7'h18) ? rs : 0)};
    check({prog_channel_poll_current_select, ground_channel_poll_current_select, prog_channel_slow_poll_enable},
      {rp[7:0], rg[13:0], rs[7:0]});
  endtask
  // fresh channel context, then every channel's current
  task automatic check_currents;
    @(negedge ref_clk);
    prog_is_battery_switch          = 8'($urandom);
    prog_contact_cleaning_current   = {$urandom, $urandom};
    ground_contact_cleaning_current = 112'({$urandom, $urandom, $urandom, $urandom});
    repeat (2) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      check(prog_poll_current[i], rp[i] ? prog_contact_cleaning_current[i] :
        prog_is_battery_switch[i] ? 8'h16 : 8'h0a);
    end
    for (int i = 0; i < 14; i++) begin
      check(ground_poll_current[i], rg[i] ? ground_contact_cleaning_current[i] : 8'h0a);
    end
  endtask
  // eight ticks with the mode off, then eight with it on
  task automatic check_strobes;
    int pc[8];
    int gc[14];
    for (int m = 0; m < 2; m++) begin
      pc = '{8{0}};
      gc = '{14{0}};
      for (int t = 0; t < 8; t++) begin
        @(negedge ref_clk);
        sleep_polling_mode = m[0];
        base_poll_tick     = 1'b1;
        #1;
        for (int i = 0; i < 14; i++) begin
          if (i < 8) pc[i] += int'(prog_poll_strobe[i] === 1'b1);
          gc[i] += int'(ground_poll_strobe[i] === 1'b1);
        end
        @(negedge ref_clk);
        base_poll_tick = 1'b0;
      end
      for (int i = 0; i < 8; i++) check(pc[i], (m == 0) ? 0 : rs[i] ? 2 : 8);
      for (int i = 0; i < 14; i++) check(gc[i], m * 8);
    end
  endtask
  // main sequence: reset, defaults, then random and all-ones passes
  initial begin
    reset = 1'b1;
    fault_status = 1'b0;
    int_flag = 1'b0;
    sleep_polling_mode = 1'b0;
    base_poll_tick = 1'b0;
    prog_is_battery_switch = 8'h00;
    prog_contact_cleaning_current = '0;
    ground_contact_cleaning_current = '0;
    rp = 0;
    rg = 0;
    rs = 0;
    exp_reply = 32'h0000_0000;
    void'($urandom(32'hf4d3));
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    check_currents();
    $display("test reset defaults done");
    for (int pass = 0; pass < 2; pass++) begin
      for (int a = 8'h16; a <= 8'h19; a++) begin
        d = pass ? 24'hffffff : 24'($urandom);
        frame(7'(a), 1'b1, d);
        frame(7'(a), 1'b0, 24'($urandom));
      end
      check_currents();
      check_strobes();
      $display("test pass %0d done", pass);
    end
    frame(7'h16, 1'b0, 24'h000000);
    summarize();
  end
endmodule

// [spi_host_model.sv]
// partner model: serial host framing 32-bit commands and collecting replies
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic ref_clk,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  // idle: select high, link clock parked low between frames
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // half link period, 40 ns, counted on falling ref clock edges
  task automatic half;
    repeat (10) @(negedge ref_clk);
  endtask
  // one frame, msb first; reply bit taken at each link clock rise
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rep);
    spi_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_mosi = cmd[i];
      half();
      spi_sclk = 1'b1;
      rep[i]   = spi_miso;
      half();
      spi_sclk = 1'b0;
    end
    half();
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // stale data must not look valid
    half();
  endtask
endmodule
